/* inc/periph_irq_pkg.sv */
package periph_irq_pkg;

	// Register byte addresses on the bus; offsets are multiples of four.
	localparam logic [7:0] ENABLE_ADDR  = 8'h8c;
	localparam logic [7:0] FLAGS_ADDR   = 8'h90;
	localparam logic [7:0] CONTROL_ADDR = 8'h94;

	localparam logic [7:0] ENABLE_RESET  = 8'h00;
	localparam logic [7:0] FLAGS_RESET   = 8'h00;
	localparam logic [1:0] CONTROL_RESET = 2'h0;

	// Enable and flag bit positions.
	localparam int SLAVE_PORT_BIT   = 7;
	localparam int ADC_DONE_BIT     = 6;
	localparam int SERIAL_RX_BIT    = 5;
	localparam int SERIAL_TX_BIT    = 4;
	localparam int SYNC_SERIAL_BIT  = 3;
	localparam int CAPCMP_ONE_BIT   = 2;
	localparam int TIMER_TWO_BIT    = 1;
	localparam int TIMER_ONE_BIT    = 0;

	// Core control bit positions.
	localparam int GLOBAL_EN_BIT = 7;
	localparam int GROUP_EN_BIT  = 6;

	localparam int NUM_SOURCES = 8;

endpackage

/* logic/peripheral_interrupt_enable.sv */
// Decided for this implementation: register access over Wishbone.
module peripheral_interrupt_enable
	import periph_irq_pkg::*;
(
	// Clock and reset.
	input  wire logic       clk_i,
	input  wire logic       rst_i,
	// Wishbone slave.
	input  wire logic       wb_cyc_i,
	input  wire logic       wb_stb_i,
	input  wire logic       wb_we_i,
	input  wire logic [7:0] wb_adr_i,
	input  wire logic [3:0] wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	output logic [31:0]     wb_dat_o,
	output logic            wb_ack_o,
	// Peripheral events, one-cycle pulses per source.
	input  wire logic [7:0] periph_event_i,
	// Request to the core.
	output logic            periph_irq_o
);


	// Register state and next values.
	logic [7:0]  peripheral_irq_enable_r;
	logic [7:0]  peripheral_irq_enable_nxt;
	logic [7:0]  peripheral_irq_flags_r;
	logic [7:0]  peripheral_irq_flags_nxt;
	logic        peripheral_group_enable_r;
	logic        peripheral_group_enable_nxt;
	logic        global_irq_enable_r;
	logic        global_irq_enable_nxt;

	// Bus answer state and next values.
	logic        ack_r;
	logic        ack_nxt;
	logic [31:0] dat_r;
	logic [31:0] dat_nxt;

	// Bus qualifiers.
	logic        bus_req;
	logic        bus_take;
	logic        bus_done;
	logic        bus_read;
	logic        lane0_wr;
	logic [7:0]  wr_byte;

	// Address selects.
	logic        sel_enable;
	logic        sel_flags;
	logic        sel_control;
	logic        sel_none;

	// Register write strobes.
	logic        enable_wr;
	logic        flags_wr;
	logic        control_wr;

	// Enable bits by source.
	logic        slave_port_irq_en;
	logic        adc_done_irq_en;
	logic        serial_rx_irq_en;
	logic        serial_tx_irq_en;
	logic        sync_serial_irq_en;
	logic        capcmp_one_irq_en;
	logic        timer_two_match_irq_en;
	logic        timer_one_ovf_irq_en;

	// Events by source.
	logic        slave_port_event;
	logic        adc_done_event;
	logic        serial_rx_event;
	logic        serial_tx_event;
	logic        sync_serial_event;
	logic        capcmp_one_event;
	logic        timer_two_match_event;
	logic        timer_one_ovf_event;

	// Flags by source.
	logic        slave_port_flag;
	logic        adc_done_flag;
	logic        serial_rx_flag;
	logic        serial_tx_flag;
	logic        sync_serial_flag;
	logic        capcmp_one_flag;
	logic        timer_two_match_flag;
	logic        timer_one_ovf_flag;

	// Pending requests by source.
	logic        slave_port_pending;
	logic        adc_done_pending;
	logic        serial_rx_pending;
	logic        serial_tx_pending;
	logic        sync_serial_pending;
	logic        capcmp_one_pending;
	logic        timer_two_match_pending;
	logic        timer_one_ovf_pending;

	// Per-source vectors and the combined request.
	logic [7:0]  enable_vec;
	logic [7:0]  event_vec;
	logic [7:0]  flag_vec;
	logic [7:0]  flag_written;
	logic [7:0]  flag_hold;
	logic [7:0]  source_pending;
	logic        any_pending;
	logic        irq_allowed;

	// Read words.
	logic [7:0]  control_rd_byte;
	logic [31:0] enable_rd_word;
	logic [31:0] flags_rd_word;
	logic [31:0] control_rd_word;
	logic [31:0] rd_word;

	// A request is taken on the edge where it is first seen and completes on the edge
	// where the master samples ack, so a write lands only at that second edge.
	assign bus_req  = wb_cyc_i & wb_stb_i;
	assign bus_take = bus_req & ~ack_r;
	assign bus_done = bus_req & ack_r;
	assign bus_read = bus_take & ~wb_we_i;
	assign lane0_wr = bus_done & wb_we_i & wb_sel_i[0];
	assign wr_byte  = wb_dat_i[7:0];

	assign sel_enable  = (wb_adr_i == ENABLE_ADDR);
	assign sel_flags   = (wb_adr_i == FLAGS_ADDR);
	assign sel_control = (wb_adr_i == CONTROL_ADDR);
	assign sel_none    = ~(sel_enable | sel_flags | sel_control);

	assign enable_wr  = lane0_wr & sel_enable;
	assign flags_wr   = lane0_wr & sel_flags;
	assign control_wr = lane0_wr & sel_control;

	assign slave_port_irq_en      = peripheral_irq_enable_r[SLAVE_PORT_BIT];
	assign adc_done_irq_en        = peripheral_irq_enable_r[ADC_DONE_BIT];
	assign serial_rx_irq_en       = peripheral_irq_enable_r[SERIAL_RX_BIT];
	assign serial_tx_irq_en       = peripheral_irq_enable_r[SERIAL_TX_BIT];
	assign sync_serial_irq_en     = peripheral_irq_enable_r[SYNC_SERIAL_BIT];
	assign capcmp_one_irq_en      = peripheral_irq_enable_r[CAPCMP_ONE_BIT];
	assign timer_two_match_irq_en = peripheral_irq_enable_r[TIMER_TWO_BIT];
	assign timer_one_ovf_irq_en   = peripheral_irq_enable_r[TIMER_ONE_BIT];

	assign slave_port_event      = periph_event_i[SLAVE_PORT_BIT];
	assign adc_done_event        = periph_event_i[ADC_DONE_BIT];
	assign serial_rx_event       = periph_event_i[SERIAL_RX_BIT];
	assign serial_tx_event       = periph_event_i[SERIAL_TX_BIT];
	assign sync_serial_event     = periph_event_i[SYNC_SERIAL_BIT];
	assign capcmp_one_event      = periph_event_i[CAPCMP_ONE_BIT];
	assign timer_two_match_event = periph_event_i[TIMER_TWO_BIT];
	assign timer_one_ovf_event   = periph_event_i[TIMER_ONE_BIT];

	assign slave_port_flag      = peripheral_irq_flags_r[SLAVE_PORT_BIT];
	assign adc_done_flag        = peripheral_irq_flags_r[ADC_DONE_BIT];
	assign serial_rx_flag       = peripheral_irq_flags_r[SERIAL_RX_BIT];
	assign serial_tx_flag       = peripheral_irq_flags_r[SERIAL_TX_BIT];
	assign sync_serial_flag     = peripheral_irq_flags_r[SYNC_SERIAL_BIT];
	assign capcmp_one_flag      = peripheral_irq_flags_r[CAPCMP_ONE_BIT];
	assign timer_two_match_flag = peripheral_irq_flags_r[TIMER_TWO_BIT];
	assign timer_one_ovf_flag   = peripheral_irq_flags_r[TIMER_ONE_BIT];

	assign enable_vec = {
		slave_port_irq_en,
		adc_done_irq_en,
		serial_rx_irq_en,
		serial_tx_irq_en,
		sync_serial_irq_en,
		capcmp_one_irq_en,
		timer_two_match_irq_en,
		timer_one_ovf_irq_en
	};

	assign event_vec = {
		slave_port_event,
		adc_done_event,
		serial_rx_event,
		serial_tx_event,
		sync_serial_event,
		capcmp_one_event,
		timer_two_match_event,
		timer_one_ovf_event
	};

	assign flag_vec = {
		slave_port_flag,
		adc_done_flag,
		serial_rx_flag,
		serial_tx_flag,
		sync_serial_flag,
		capcmp_one_flag,
		timer_two_match_flag,
		timer_one_ovf_flag
	};

	// An event and a software clear in one cycle: the event wins, so none is lost.
	genvar g;
	generate
		for (g = 0; g < NUM_SOURCES; g++) begin : g_src
			assign flag_written[g]   = flags_wr ? wr_byte[g] : flag_vec[g];
			assign flag_hold[g]      = event_vec[g] | flag_written[g];
			assign source_pending[g] = flag_vec[g] & enable_vec[g];
		end
	endgenerate

	assign slave_port_pending      = source_pending[SLAVE_PORT_BIT];
	assign adc_done_pending        = source_pending[ADC_DONE_BIT];
	assign serial_rx_pending       = source_pending[SERIAL_RX_BIT];
	assign serial_tx_pending       = source_pending[SERIAL_TX_BIT];
	assign sync_serial_pending     = source_pending[SYNC_SERIAL_BIT];
	assign capcmp_one_pending      = source_pending[CAPCMP_ONE_BIT];
	assign timer_two_match_pending = source_pending[TIMER_TWO_BIT];
	assign timer_one_ovf_pending   = source_pending[TIMER_ONE_BIT];

	assign any_pending = slave_port_pending
		| adc_done_pending
		| serial_rx_pending
		| serial_tx_pending
		| sync_serial_pending
		| capcmp_one_pending
		| timer_two_match_pending
		| timer_one_ovf_pending;
	assign irq_allowed = peripheral_group_enable_r & global_irq_enable_r;

	assign peripheral_irq_enable_nxt = enable_wr ? wr_byte
		: peripheral_irq_enable_r;
	assign peripheral_irq_flags_nxt = flag_hold;
	assign peripheral_group_enable_nxt = control_wr ? wb_dat_i[GROUP_EN_BIT]
		: peripheral_group_enable_r;
	assign global_irq_enable_nxt = control_wr ? wb_dat_i[GLOBAL_EN_BIT]
		: global_irq_enable_r;

	// Unused control bits read as zero.
	assign control_rd_byte = {global_irq_enable_r, peripheral_group_enable_r, 6'h00};
	assign enable_rd_word  = {24'h00_0000, peripheral_irq_enable_r};
	assign flags_rd_word   = {24'h00_0000, peripheral_irq_flags_r};
	assign control_rd_word = {24'h00_0000, control_rd_byte};
	assign rd_word = sel_none ? 32'h0000_0000 :
		sel_enable ? enable_rd_word :
		sel_flags ? flags_rd_word :
		control_rd_word;

	// Ack is a one-cycle pulse; a request held past it is taken again and answered every second cycle.
	assign ack_nxt = bus_take;
	assign dat_nxt = bus_read ? rd_word : 32'h0000_0000;

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peripheral_irq_enable_r <= ENABLE_RESET;
		end else begin
			peripheral_irq_enable_r <= peripheral_irq_enable_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peripheral_irq_flags_r <= FLAGS_RESET;
		end else begin
			peripheral_irq_flags_r <= peripheral_irq_flags_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			peripheral_group_enable_r <= CONTROL_RESET[1];
			global_irq_enable_r       <= CONTROL_RESET[0];
		end else begin
			peripheral_group_enable_r <= peripheral_group_enable_nxt;
			global_irq_enable_r       <= global_irq_enable_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			ack_r <= 1'b0;
		end else begin
			ack_r <= ack_nxt;
		end
	end

	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			dat_r <= 32'h0000_0000;
		end else begin
			dat_r <= dat_nxt;
		end
	end

	assign wb_ack_o = ack_r;
	assign wb_dat_o = dat_r;
	// The request is a level from registers, so it drops as soon as the last pending flag is cleared.
	assign periph_irq_o = any_pending & irq_allowed;

endmodule

/* test/periph_model.sv */
module periph_model (input wire logic clk_i, input wire logic [7:0] f_i,
	output logic [7:0] ev_o = 8'h00); timeunit 1ns; timeprecision 1ps;
	// Events last one cycle, as a peripheral finishing a job.
	always_ff @(posedge clk_i) ev_o <= f_i;
endmodule

/* test/pie_asserts.sv */
module pie_asserts
	import periph_irq_pkg::*;
(
	// Clock and reset.
	input  wire logic        clk_i,
	input  wire logic        rst_i,
	// Bus as seen at the top ports.
	input  wire logic        wb_cyc_i,
	input  wire logic        wb_stb_i,
	input  wire logic        wb_we_i,
	input  wire logic [7:0]  wb_adr_i,
	input  wire logic [3:0]  wb_sel_i,
	input  wire logic [31:0] wb_dat_i,
	input  wire logic [31:0] wb_dat_o,
	input  wire logic        wb_ack_o,
	// Events and request.
	input  wire logic [7:0]  periph_event_i,
	input  wire logic        periph_irq_o
);
	logic [7:0] en_seen_r;
	logic       grp_seen_r;
	logic       glb_seen_r;
	wire        done_wr = wb_cyc_i & wb_stb_i & wb_ack_o & wb_we_i & wb_sel_i[0];
	wire        mapped  = (wb_adr_i == ENABLE_ADDR) | (wb_adr_i == FLAGS_ADDR)
		| (wb_adr_i == CONTROL_ADDR);

	// Mirror of what software wrote, taken at the edge where ack is sampled.
	always_ff @(posedge clk_i) begin
		if (rst_i) begin
			en_seen_r  <= 8'h00;
			grp_seen_r <= 1'b0;
			glb_seen_r <= 1'b0;
		end else if (done_wr) begin
			if (wb_adr_i == ENABLE_ADDR) begin
				en_seen_r <= wb_dat_i[7:0];
			end
			if (wb_adr_i == CONTROL_ADDR) begin
				grp_seen_r <= wb_dat_i[GROUP_EN_BIT];
				glb_seen_r <= wb_dat_i[GLOBAL_EN_BIT];
			end
		end
	end

	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	a_ack_next: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
		else $error("request not answered in one cycle");
	a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack stood longer than one cycle");
	a_reset_quiet: assert property ($past(rst_i) |-> !wb_ack_o && !periph_irq_o)
		else $error("ack or request high right after reset");
	a_unmapped_zero: assert property (wb_ack_o && !mapped |-> wb_dat_o == 32'h0000_0000)
		else $error("unmapped read not zero");
	a_group_blocks: assert property (!grp_seen_r |-> !periph_irq_o)
		else $error("request with group enable off");
	a_global_blocks: assert property (!glb_seen_r |-> !periph_irq_o)
		else $error("request with global enable off");
	a_event_raises: assert property (((periph_event_i & en_seen_r) != 8'h00)
		&& grp_seen_r && glb_seen_r && !done_wr |=> periph_irq_o)
		else $error("enabled event raised no request");
endmodule
bind peripheral_interrupt_enable pie_asserts chk (.*);

/* test/tb_peripheral_interrupt_enable.sv */
module tb_peripheral_interrupt_enable; timeunit 1ns; timeprecision 1ps; import periph_irq_pkg::*;
	logic clk_i = 0, rst_i = 1, c = 0, w = 0, ack, irq; logic [7:0] a = 0, f = 0, ev, m;
	logic [31:0] d = 0, q, r; int fails = 0, num_checks = 0, t = 0; logic [3:0] s = 4'h1;
	peripheral_interrupt_enable uut (.clk_i, .rst_i, .wb_cyc_i(c), .wb_stb_i(c), .wb_we_i(w),
		.wb_adr_i(a), .wb_sel_i(s), .wb_dat_i(d), .wb_dat_o(q), .wb_ack_o(ack),
		.periph_event_i(ev), .periph_irq_o(irq));
	periph_model pm (.clk_i, .f_i(f), .ev_o(ev));
	initial forever #2 clk_i = ~clk_i;
	always @(posedge clk_i) if (++t > 2000) begin fails++; give_verdict; end
	task give_verdict; $display("checks %0d fails %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish; endtask
	task ck(logic [31:0] g, e); num_checks++;
		if (g !== e) begin fails++; $display("[FAIL] %0t got %h", $time, g); end endtask
	task wb(logic we, logic [7:0] ad, logic [31:0] dt); c <= 1; w <= we; a <= ad; d <= dt;
		do @(posedge clk_i); while (ack !== 1); r = q; c <= 0; @(posedge clk_i); endtask
	initial begin repeat (10) @(posedge clk_i); rst_i <= 0; @(posedge clk_i);
		wb(0, ENABLE_ADDR, 0); ck(r, 0);
		ck(irq, 0);
		wb(1, ENABLE_ADDR, 8'ha5); wb(0, ENABLE_ADDR, 0); ck(r, 8'ha5);
		wb(0, 8'h88, 0); ck(r, 0);
		wb(1, 8'h88, 8'hff); wb(0, 8'h88, 0); ck(r, 0);
		s <= 4'h0; wb(1, ENABLE_ADDR, 8'h3c); s <= 4'h1;
		wb(0, ENABLE_ADDR, 0); ck(r, 8'ha5);
		wb(1, FLAGS_ADDR, 0); c <= 1; w <= 1; a <= FLAGS_ADDR; d <= 0; f <= 8'h01;
		@(posedge clk_i); f <= 0; @(posedge clk_i); c <= 0; @(posedge clk_i);
		wb(0, FLAGS_ADDR, 0); ck(r, 8'h01);
		$display("test registers done");
		for (int k = 0; k < 8; k++) begin m = 8'h01 << k;
			wb(1, FLAGS_ADDR, 0); wb(1, ENABLE_ADDR, m); wb(1, CONTROL_ADDR, 8'hc0);
			f <= ~m; @(posedge clk_i); f <= m; @(posedge clk_i); f <= 0; @(posedge clk_i);
			ck(irq, 0); @(posedge clk_i); ck(irq, 1);
			wb(1, CONTROL_ADDR, 8'h80); ck(irq, 0);
			wb(1, CONTROL_ADDR, 8'h40); ck(irq, 0);
			wb(0, FLAGS_ADDR, 0); ck(r, 8'hff);
			$display("test %0d done", k); end
		give_verdict; end
endmodule
